// ---- ncr_pkg.sv ----
// Constants for the NCO and PLL control register bank.
// Assumes an APB master on pclk; register indices map to byte address index*4.
// Summary of operation
// - Phase offset adds to accumulator top 16 bits; sum addresses sine/cosine tables.
// - With auto-sync enabled, any phase offset write raises an auto-sync event.
// - Auto-sync loads phase offset and both step halves into mixer together.
// - Step word writes only touch staging copies until a sync.
// - Frequency is a 32-bit two's complement step, low at 0x14, high 0x15.
// - PLL reset bit 12 grounds loop filter; clearing it restarts the PLL.
// - Divider-sync enable bit 11, reset 1, lets sync input realign N dividers.
// - PLL enable bit 10 selects PLL clock; cleared bypasses the PLL.
// - Charge pump bits 7:6: 00 none, 01 single, 11 dual, 10 unused.
// - Prescaler bits 5:3: codes 1..7 divide by code, 000 by 8; reset 001.
// - Bits 2:0 read loop voltage, 0.4125 V steps; writes ignored.
// - Reserved registers 0x11, 0x13, 0x16, 0x17 reset to 0x0000.
// - VCO coarse field lives in a separate PLL register, reset zero.
`default_nettype none
package ncr_pkg;
  // -----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // -----------------------------------------------------------------
  localparam logic [7:0]  IDX_RSVD_A    = 8'h11;
  localparam logic [7:0]  IDX_ANGLE     = 8'h12;
  localparam logic [7:0]  IDX_RSVD_B    = 8'h13;
  localparam logic [7:0]  IDX_STEP_LO   = 8'h14;
  localparam logic [7:0]  IDX_STEP_HI   = 8'h15;
  localparam logic [7:0]  IDX_RSVD_C    = 8'h16;
  localparam logic [7:0]  IDX_RSVD_D    = 8'h17;
  localparam logic [7:0]  IDX_SYNTH     = 8'h18;
  localparam logic [7:0]  IDX_VCO_TUNE  = 8'h1A;
  // -----------------------------------------------------------------
  // Synth control fields and reset values
  // -----------------------------------------------------------------
  localparam int          BIT_PLL_RST   = 12;
  localparam int          BIT_NDIV_SYNC = 11;
  localparam int          BIT_PLL_ENA   = 10;
  localparam int          CP_LSB        = 6;
  localparam int          PRE_LSB       = 3;
  localparam int          VCO_LSB       = 10;
  localparam logic [15:0] RST_ZERO      = 16'h0000;
  localparam logic [2:0]  RST_RSVD_HI   = 3'h1;
  localparam logic        RST_NDIV_SYNC = 1'b1;
  localparam logic [2:0]  RST_PRESCALE  = 3'h1;
  localparam logic [5:0]  RST_VCO       = 6'h00;
  localparam logic [1:0]  CP_NONE       = 2'h0;
  localparam logic [1:0]  CP_SINGLE     = 2'h1;
  localparam logic [1:0]  CP_DUAL       = 2'h3;
  localparam logic [2:0]  LOCK_LOW      = 3'h2;
  localparam logic [2:0]  LOCK_HIGH     = 3'h5;
endpackage : ncr_pkg
`default_nettype wire

// ---- ncr_regs.sv ----
// NCO and PLL control register bank with APB slave and fine-mixer phase path.
// Assumes lfvolt_code and sync_in are asynchronous and pass two flops here.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ncr_regs (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Mixer
  input  wire logic        sample_en,
  input  wire logic        autosync_ena,
  output logic      [15:0] lut_addr,
  output logic             autosync_pulse,
  // PLL
  input  wire logic [2:0]  lfvolt_code,
  input  wire logic        sync_in,
  output logic             lpf_ground,
  output logic             pll_restart,
  output logic             ndiv_resync,
  output logic             clk_sel_pll,
  output logic      [1:0]  charge_pump_sel,
  output logic      [3:0]  prescale_div,
  output logic      [5:0]  vco_coarse,
  output logic             lock_ok
);
  import ncr_pkg::*;

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [15:0] angle_bias_reg, step_lo_reg, step_hi_reg;
  logic [15:0] act_angle_reg;
  logic [31:0] act_step_reg, acc_reg;
  logic [2:0]  rsvd_hi_reg;
  logic        pll_rst_reg, ndiv_sync_reg, pll_ena_reg;
  logic [1:0]  cp_reg;
  logic [2:0]  pre_reg;
  logic [5:0]  vco_reg;
  logic [2:0]  lf_s1_reg, lf_s2_reg;
  logic [2:0]  lf_s3_reg, lf_hold_reg;
  logic        sy_s1_reg, sy_s2_reg, sy_d_reg;

  logic        wr_en, rd_en;
  logic [7:0]  idx;
  logic        mapped, idx_ok;

  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i >= IDX_RSVD_A && i <= IDX_SYNTH) || i == IDX_VCO_TUNE;
  endfunction : is_mapped

  // Word-aligned only; misaligned addresses count as unmapped
  assign idx    = paddr[9:2];
  assign idx_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign mapped = idx_ok && is_mapped(idx);
  assign wr_en  = psel && penable && pwrite && pready && mapped;
  assign rd_en  = psel && !penable;

  // ---------------------------------------------------------------
  // APB answer: no wait state, data registered in setup
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rd_en) begin
        prdata <= 32'h0000_0000;
        if (idx_ok && !pwrite) begin
          unique case (idx)
            IDX_ANGLE:    prdata <= {16'h0000, angle_bias_reg};
            IDX_STEP_LO:  prdata <= {16'h0000, step_lo_reg};
            IDX_STEP_HI:  prdata <= {16'h0000, step_hi_reg};
            IDX_SYNTH:    prdata <= {16'h0000, rsvd_hi_reg, pll_rst_reg, ndiv_sync_reg, pll_ena_reg,
                                     2'h0, cp_reg, pre_reg, lf_hold_reg};
            IDX_VCO_TUNE: prdata <= {16'h0000, vco_reg, 10'h000};
            default:      prdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  // Reserved words are not stored: they only ever read their zero reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      angle_bias_reg <= RST_ZERO;
      step_lo_reg    <= RST_ZERO;
      step_hi_reg    <= RST_ZERO;
      rsvd_hi_reg    <= RST_RSVD_HI;
      pll_rst_reg    <= 1'b0;
      ndiv_sync_reg  <= RST_NDIV_SYNC;
      pll_ena_reg    <= 1'b0;
      cp_reg         <= CP_NONE;
      pre_reg        <= RST_PRESCALE;
      vco_reg        <= RST_VCO;
    end else if (wr_en) begin
      unique case (idx)
        IDX_ANGLE:    angle_bias_reg <= pwdata[15:0];
        IDX_STEP_LO:  step_lo_reg    <= pwdata[15:0];
        IDX_STEP_HI:  step_hi_reg    <= pwdata[15:0];
        IDX_SYNTH: begin
          rsvd_hi_reg   <= pwdata[15:13];
          pll_rst_reg   <= pwdata[BIT_PLL_RST];
          ndiv_sync_reg <= pwdata[BIT_NDIV_SYNC];
          pll_ena_reg   <= pwdata[BIT_PLL_ENA];
          cp_reg        <= pwdata[CP_LSB+:2];
          pre_reg       <= pwdata[PRE_LSB+:3];
        end
        IDX_VCO_TUNE: vco_reg <= pwdata[VCO_LSB+:6];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Mixer: auto-sync transfer and accumulator
  // ---------------------------------------------------------------
  logic sync_now;
  assign sync_now = wr_en && idx == IDX_ANGLE && autosync_ena;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_angle_reg  <= RST_ZERO;
      act_step_reg   <= {RST_ZERO, RST_ZERO};
      autosync_pulse <= 1'b0;
    end else begin
      autosync_pulse <= sync_now;
      if (sync_now) begin
        // New phase comes from the bus, the step from the staged halves
        act_angle_reg <= pwdata[15:0];
        act_step_reg  <= {step_hi_reg, step_lo_reg};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg  <= {RST_ZERO, RST_ZERO};
      lut_addr <= RST_ZERO;
    end else if (sample_en) begin
      acc_reg  <= acc_reg + act_step_reg;
      lut_addr <= acc_reg[31:16] + act_angle_reg;
    end
  end

  // ---------------------------------------------------------------
  // PLL pin synchronisers and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lf_s1_reg <= 3'h0;
      lf_s2_reg <= 3'h0;
      lf_s3_reg   <= 3'h0;
      lf_hold_reg <= 3'h0;
      sy_s1_reg <= 1'b0;
      sy_s2_reg <= 1'b0;
      sy_d_reg  <= 1'b0;
    end else begin
      lf_s1_reg <= lfvolt_code;
      lf_s2_reg <= lf_s1_reg;
      lf_s3_reg <= lf_s2_reg;
      // Code bits may settle on different edges: take a code once two samples agree
      if (lf_s2_reg == lf_s3_reg) lf_hold_reg <= lf_s2_reg;
      sy_s1_reg <= sync_in;
      sy_s2_reg <= sy_s1_reg;
      sy_d_reg  <= sy_s2_reg;
    end
  end

  logic [3:0] div_dec;
  always_comb begin
    div_dec = (pre_reg == 3'h0) ? 4'h8 : {1'b0, pre_reg};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lpf_ground      <= 1'b0;
      pll_restart     <= 1'b0;
      ndiv_resync     <= 1'b0;
      clk_sel_pll     <= 1'b0;
      charge_pump_sel <= CP_NONE;
      prescale_div    <= 4'h0;
      vco_coarse      <= RST_VCO;
      lock_ok         <= 1'b0;
    end else begin
      lpf_ground      <= pll_rst_reg;
      pll_restart     <= lpf_ground && !pll_rst_reg;
      ndiv_resync     <= ndiv_sync_reg && sy_s2_reg && !sy_d_reg;
      clk_sel_pll     <= pll_ena_reg;
      // Unused code 10 drives no pump rather than an undefined one
      charge_pump_sel <= (cp_reg == 2'h2) ? CP_NONE : cp_reg;
      prescale_div    <= div_dec;
      vco_coarse      <= vco_reg;
      lock_ok         <= lf_hold_reg >= LOCK_LOW && lf_hold_reg <= LOCK_HIGH;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_stage_hold;
    @(posedge pclk) disable iff (!presetn)
      !sync_now |=> act_step_reg == $past(act_step_reg);
  endproperty
  a_stage_hold: assert property (p_stage_hold) else $error("active step changed without sync");

  property p_sync_load;
    @(posedge pclk) disable iff (!presetn)
      sync_now |=> act_step_reg == {$past(step_hi_reg), $past(step_lo_reg)} && autosync_pulse;
  endproperty
  a_sync_load: assert property (p_sync_load) else $error("auto-sync did not load step");

  property p_sync_cause;
    @(posedge pclk) disable iff (!presetn)
      autosync_pulse |-> $past(autosync_ena) && $past(wr_en) && $past(idx) == IDX_ANGLE;
  endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("spurious auto-sync");

  property p_acc;
    @(posedge pclk) disable iff (!presetn)
      sample_en |=> acc_reg == $past(acc_reg) + $past(act_step_reg);
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator step wrong");

  property p_lut;
    @(posedge pclk) disable iff (!presetn)
      sample_en |=> lut_addr == 16'($past(acc_reg[31:16]) + $past(act_angle_reg));
  endproperty
  a_lut: assert property (p_lut) else $error("table address wrong");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
      $fell(pll_rst_reg) |=> pll_restart ##1 !pll_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart pulse");

  property p_ground;
    @(posedge pclk) disable iff (!presetn)
      pll_rst_reg [*2] |-> lpf_ground;
  endproperty
  a_ground: assert property (p_ground) else $error("loop filter not grounded");

  property p_resync;
    @(posedge pclk) disable iff (!presetn)
      ndiv_resync |-> $past(ndiv_sync_reg);
  endproperty
  a_resync: assert property (p_resync) else $error("resync while disabled");

  property p_pump;
    @(posedge pclk) disable iff (!presetn)
      charge_pump_sel != 2'h2;
  endproperty
  a_pump: assert property (p_pump) else $error("unused pump code driven");

  property p_div;
    @(posedge pclk) disable iff (!presetn)
      prescale_div == 4'h8 |-> $past(pre_reg) == 3'h0;
  endproperty
  a_div: assert property (p_div) else $error("divide by 8 decode wrong");

  property p_clksel;
    @(posedge pclk) disable iff (!presetn)
      clk_sel_pll == $past(pll_ena_reg);
  endproperty
  a_clksel: assert property (p_clksel) else $error("clock select not following enable");

  property p_angle_load;
    @(posedge pclk) disable iff (!presetn)
      sync_now |=> act_angle_reg == $past(pwdata[15:0]);
  endproperty
  a_angle_load: assert property (p_angle_load) else $error("auto-sync did not load phase");

  property p_angle_hold;
    @(posedge pclk) disable iff (!presetn)
      !sync_now |=> $stable(act_angle_reg);
  endproperty
  a_angle_hold: assert property (p_angle_hold) else $error("active phase changed without sync");

  property p_rsvd_read;
    @(posedge pclk) disable iff (!presetn)
      pready && !pwrite && (idx == IDX_RSVD_A || idx == IDX_RSVD_B || idx == IDX_RSVD_C || idx == IDX_RSVD_D)
      |-> prdata == 32'h0000_0000;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved word read not zero");

  property p_lf_read;
    @(posedge pclk) disable iff (!presetn)
      pready && !pwrite && idx_ok && idx == IDX_SYNTH |-> prdata[2:0] == $past(lf_hold_reg);
  endproperty
  a_lf_read: assert property (p_lf_read) else $error("loop voltage field wrong");

  property p_rst_write;
    @(posedge pclk) disable iff (!presetn)
      wr_en && idx == IDX_SYNTH |=> pll_rst_reg == $past(pwdata[BIT_PLL_RST]);
  endproperty
  a_rst_write: assert property (p_rst_write) else $error("pll reset bit not written");

  property p_resync_edge;
    @(posedge pclk) disable iff (!presetn)
      ndiv_resync |-> $past(sy_s2_reg) && !$past(sy_d_reg);
  endproperty
  a_resync_edge: assert property (p_resync_edge) else $error("resync without sync edge");

  property p_div_follow;
    @(posedge pclk) disable iff (!presetn)
      pre_reg != 3'h0 |=> prescale_div == {1'b0, $past(pre_reg)};
  endproperty
  a_div_follow: assert property (p_div_follow) else $error("prescale divide wrong");

  property p_pump_follow;
    @(posedge pclk) disable iff (!presetn)
      cp_reg != 2'h2 |=> charge_pump_sel == $past(cp_reg);
  endproperty
  a_pump_follow: assert property (p_pump_follow) else $error("pump select not following field");

  property p_vco;
    @(posedge pclk) disable iff (!presetn)
      vco_coarse == $past(vco_reg);
  endproperty
  a_vco: assert property (p_vco) else $error("coarse tune not following register");

  property p_lock;
    @(posedge pclk) disable iff (!presetn)
      lock_ok == ($past(lf_hold_reg) >= LOCK_LOW && $past(lf_hold_reg) <= LOCK_HIGH);
  endproperty
  a_lock: assert property (p_lock) else $error("lock window flag wrong");

  // ---------------------------------------------------------------
  // Cover points
  // ---------------------------------------------------------------
  c_sync:    cover property (@(posedge pclk) disable iff (!presetn) sync_now);
  c_restart: cover property (@(posedge pclk) disable iff (!presetn) pll_restart);
  c_resync:  cover property (@(posedge pclk) disable iff (!presetn) ndiv_resync);
  c_err:     cover property (@(posedge pclk) disable iff (!presetn) pslverr && pready);
  c_div8:    cover property (@(posedge pclk) disable iff (!presetn) prescale_div == 4'h8);
endmodule : ncr_regs
`default_nettype wire

// ---- tb_ncr_regs.sv ----
// Self-checking bench for the NCO and PLL control register bank.
// Assumes ncr_pkg and ncr_regs are compiled first; the bench is the APB master.
`timescale 1ns/1ps
`default_nettype none
module tb_ncr_regs;
  import ncr_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, sample_en, autosync_ena, sync_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic [2:0]  lfvolt_code;
  logic        pready, pslverr, err, autosync_pulse, lpf_ground, pll_restart;
  logic        ndiv_resync, clk_sel_pll, lock_ok;
  logic [15:0] lut_addr, l1;
  logic [1:0]  charge_pump_sel;
  logic [3:0]  prescale_div;
  logic [5:0]  vco_coarse;
  logic [7:0]  rsv [4];
  int          failures, comparisons, cycles, n_as, n_rst, n_nd;
  ncr_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                .pslverr, .sample_en, .autosync_ena, .lut_addr, .autosync_pulse, .lfvolt_code,
                .sync_in, .lpf_ground, .pll_restart, .ndiv_resync, .clk_sel_pll,
                .charge_pump_sel, .prescale_div, .vco_coarse, .lock_ok);
  always #20 pclk = ~pclk;
  // ---------------------------------------------------------------
  // Pulse counters and timeout
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    cycles++;
    if (autosync_pulse === 1'b1) n_as++;
    if (pll_restart === 1'b1) n_rst++;
    if (ndiv_resync === 1'b1) n_nd++;
    if (cycles == 6000) begin
      failures++;
      end_of_test();
    end
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Waits for pready with no assumed latency
  task automatic apb(input int w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= 1'(w);
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_n(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_n
  task automatic step_once();
    @(posedge pclk) sample_en <= 1'b1;
    @(posedge pclk) sample_en <= 1'b0;
    wait_n(3);
  endtask : step_once
  task automatic toggle_sync();
    @(posedge pclk) sync_in <= 1'b1;
    wait_n(6);
    sync_in <= 1'b0;
    wait_n(4);
  endtask : toggle_sync
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    pclk         = 1'b0;
    presetn      = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = '0;
    pwdata       = '0;
    sample_en    = 1'b0;
    autosync_ena = 1'b0;
    sync_in      = 1'b0;
    lfvolt_code  = 3'h3;
    rsv = '{IDX_RSVD_A, IDX_RSVD_B, IDX_RSVD_C, IDX_RSVD_D};
    wait_n(12);
    presetn <= 1'b1;
    apb(0, IDX_ANGLE, 0);    check(rd, 0);
    apb(0, IDX_STEP_LO, 0);  check(rd, 0);
    apb(0, IDX_STEP_HI, 0);  check(rd, 0);
    apb(0, IDX_VCO_TUNE, 0); check(rd, 0);
    apb(0, IDX_SYNTH, 0);    check(rd, 32'h0000_280B);
    check(32'(lock_ok), 1);
    check(32'(clk_sel_pll), 0);
    check(32'(lpf_ground), 0);
    check(32'(charge_pump_sel), 0);
    check(32'(prescale_div), 1);
    foreach (rsv[k]) begin
      apb(1, rsv[k], 32'h0000_FFFF);
      apb(0, rsv[k], 0); check(rd, 0);
    end
    apb(0, 8'hFF, 0); check(32'(err), 1); check(rd, 0);
    $display("test reset_values done");
    toggle_sync(); check(n_nd, 1);
    $display("test divider_sync done");
    autosync_ena <= 1'b1;
    apb(1, IDX_STEP_LO, 0); apb(1, IDX_STEP_HI, 32'h0000_0001);
    check(n_as, 0);
    apb(1, IDX_ANGLE, 32'h0000_0100); wait_n(3); check(n_as, 1);
    step_once(); l1 = lut_addr;
    step_once(); check(32'(lut_addr), 32'(l1 + 16'h1));
    apb(1, IDX_STEP_HI, 32'h0000_FFFF);
    step_once(); check(32'(lut_addr), 32'(l1 + 16'h2));
    apb(1, IDX_ANGLE, 32'h0000_0300); wait_n(3);
    step_once(); check(32'(lut_addr), 32'(l1 + 16'h0203));
    step_once(); check(32'(lut_addr), 32'(l1 + 16'h0202));
    check(n_as, 2);
    autosync_ena <= 1'b0;
    apb(1, IDX_ANGLE, 0); wait_n(3); check(n_as, 2);
    $display("test mixer done");
    apb(1, IDX_SYNTH, 32'h0000_14C7); wait_n(2);
    check(32'(lpf_ground), 1);
    check(32'(clk_sel_pll), 1);
    check(32'(charge_pump_sel), 3);
    check(32'(prescale_div), 8);
    apb(0, IDX_SYNTH, 0); check(rd, 32'h0000_14C3);
    for (int i = 0; i < 8; i++) begin
      d = 32'h0000_0400 | (32'(i % 4) << 6) | (32'(i) << 3);
      apb(1, IDX_SYNTH, d); wait_n(2);
      check(32'(prescale_div), (i == 0) ? 8 : i);
      check(32'(charge_pump_sel), (i % 4 == 2) ? 0 : i % 4);
    end
    check(n_rst, 1); check(32'(lpf_ground), 0);
    toggle_sync(); check(n_nd, 1);
    lfvolt_code <= 3'h7; wait_n(6);
    check(32'(lock_ok), 0);
    apb(0, IDX_SYNTH, 0); check(rd, 32'h0000_04FF);
    $display("test synth_control done");
    apb(1, IDX_VCO_TUNE, 32'h0000_A800); wait_n(2);
    check(32'(vco_coarse), 32'h2A);
    $display("test vco_tune done");
    end_of_test();
  end
endmodule : tb_ncr_regs
`default_nettype wire
